// ### tb_top.sv
// self-checking bench for the transmit port, interrupt and fifo control
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("Error t=%0t got %h exp %h", $time, g, e); \
    end end
module tb_top;
    logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, hold = 1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, r, v, e;
    logic reg_rvalid, tx_out_valid, tx_out_ready, rx_fifo_flush, irq_req;
    logic [7:0] tx_out_data, irq_enable_bits, irq_ident_code, taken_data;
    logic [2:0] tx_level;
    logic rx_fifo_empty = 1, rx_fifo_full = 0, enhanced_mode = 0;
    logic [6:0] src = 7'h00, tx_trigger, rx_trigger;
    logic fifo_mode, taken;
    logic [3:0] line_state_flags;
    logic [31:0] seed = 32'h5;
    logic [7:0] expq[$];
    int miscompares = 0, comparisons = 0;
    always #2 clk = ~clk;
    utic_ctrl i_utic_ctrl (.clk(clk), .reset(reset), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
        .tx_out_data(tx_out_data), .tx_level(tx_level),
        .rx_fifo_empty(rx_fifo_empty), .rx_fifo_full(rx_fifo_full),
        .rx_fifo_flush(rx_fifo_flush), .src_rx_error(src[0]),
        .src_rx_data(src[1]), .src_rx_timeout(src[2]), .src_modem(src[3]),
        .src_xoff(src[4]), .src_rts_dtr(src[5]), .src_cts_dsr(src[6]),
        .enhanced_mode(enhanced_mode), .irq_req(irq_req),
        .irq_enable_bits(irq_enable_bits), .irq_ident_code(irq_ident_code),
        .fifo_mode(fifo_mode), .tx_trigger(tx_trigger),
        .rx_trigger(rx_trigger), .line_state_flags(line_state_flags));
    utic_sink i_utic_sink (.clk(clk), .reset(reset), .hold(hold),
        .valid(tx_out_valid), .ready(tx_out_ready), .data(tx_out_data),
        .taken(taken), .taken_data(taken_data));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // highest enabled source, or the idle code
    function automatic logic [7:0] exp_id(logic [6:0] s, logic [7:0] en,
                                          logic txe);
        if (s[0] && en[2]) return 8'hc6;
        if (s[1] && en[0]) return 8'hc4;
        if (s[2] && en[0]) return 8'hcc;
        if (txe && en[1]) return 8'hc2;
        if (s[3] && en[3]) return 8'hc0;
        if (s[4] && en[4]) return 8'hd0;
        if ((s[5] && en[5]) || (s[6] && en[6])) return 8'he0;
        return 8'hc1;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_rd = 1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 0;
        `CHK(reg_rvalid, 1'b1)
        d = reg_rdata;
        @(negedge clk);
    endtask
    // lets the sink take everything, stalling at random
    task automatic drain();
        for (int i = 0; i < 80 && tx_level !== 3'h0; i++) begin
            hold = xs() & 1;
            @(negedge clk);
        end
        hold = 0;
        repeat (2) @(negedge clk);
        `CHK(tx_level, 3'h0)
        `CHK(expq.size(), 0)
    endtask
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        if (taken) begin
            e = expq.size() ? expq.pop_front() : 8'hxx;
            `CHK(taken_data, e)
        end
    end
    initial begin
        #40000;
        miscompares++;
        summarize();
    end

    initial begin
        repeat (12) @(negedge clk);
        reset = 0;
        @(negedge clk);
        `CHK(irq_enable_bits, 8'h00)
        `CHK(irq_ident_code, 8'hc1)
        `CHK(fifo_mode, 1'b0)
        `CHK(rx_trigger, 7'h01)
        `CHK(line_state_flags, 4'h5)
        rd(8'h02, r);
        `CHK(r, 8'hc1)
        rd(8'h07, r);
        `CHK(r, 8'h00)
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = xs();
            wr(8'h01, v);
            rd(8'h01, r);
            `CHK(r, v)
            `CHK(irq_enable_bits, v)
        end
        $display("test enable done");
        for (int i = 0; i < 60; i++) begin
            v = (i < 7) ? 8'h7f : xs();
            src = (i < 7) ? 7'h7f << i : xs();
            wr(8'h01, v);
            `CHK(irq_ident_code, exp_id(src, v, 0))
            `CHK(irq_req, exp_id(src, v, 0) != 8'hc1)
            `CHK(irq_ident_code[0], !irq_req)
        end
        src = 7'h40;
        wr(8'h01, 8'h7f);
        `CHK(irq_ident_code, 8'he0)
        src = 7'h00;
        wr(8'h01, 8'h00);
        $display("test priority done");
        wr(8'h02, 8'h01);
        for (int i = 0; i < 5; i++) begin
            v = xs();
            wr(8'h00, v);
            if (i < 4) expq.push_back(v);
        end
        `CHK(tx_level, 3'h4)
        `CHK(line_state_flags[1:0], 2'h2)
        drain();
        `CHK(line_state_flags[1:0], 2'h1)
        wr(8'h01, 8'h02);
        `CHK(irq_ident_code, 8'hc2)
        `CHK(irq_req, 1'b1)
        rd(8'h02, r);
        `CHK(r, 8'hc2)
        `CHK(irq_ident_code, 8'hc1)
        hold = 1;
        wr(8'h00, 8'h3c);
        expq.push_back(8'h3c);
        drain();
        hold = 1;
        `CHK(irq_ident_code, 8'hc2)
        wr(8'h00, 8'ha5);
        `CHK(irq_ident_code, 8'hc1)
        wr(8'h00, 8'h5a);
        wr(8'h02, 8'h05);
        @(negedge clk);
        `CHK(tx_level, 3'h0)
        `CHK(irq_ident_code, 8'hc2)
        reg_addr = 8'h02;
        reg_wdata = 8'h03;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
        `CHK(rx_fifo_flush, 1'b1)
        @(negedge clk);
        `CHK(rx_fifo_flush, 1'b0)
        $display("test queue done");
        wr(8'h02, 8'h00);
        `CHK(fifo_mode, 1'b0)
        wr(8'h00, 8'h81);
        wr(8'h00, 8'h18);
        expq.push_back(8'h81);
        `CHK(tx_level, 3'h1)
        drain();
        $display("test single done");
        for (int k = 0; k < 8; k++) begin
            enhanced_mode = k[2];
            v = {k[1:0], k[1:0], 4'h1};
            wr(8'h02, v);
            `CHK(fifo_mode, 1'b1)
            case (k)
                0, 1, 2, 3: `CHK(tx_trigger, 7'h00)
                4: `CHK(tx_trigger, 7'd16)
                5: `CHK(tx_trigger, 7'd32)
                6: `CHK(tx_trigger, 7'd64)
                7: `CHK(tx_trigger, 7'd112)
            endcase
            case (k)
                0: `CHK(rx_trigger, 7'd1)
                1: `CHK(rx_trigger, 7'd4)
                2: `CHK(rx_trigger, 7'd8)
                3: `CHK(rx_trigger, 7'd14)
                4: `CHK(rx_trigger, 7'd15)
                5: `CHK(rx_trigger, 7'd31)
                6: `CHK(rx_trigger, 7'd63)
                7: `CHK(rx_trigger, 7'd111)
            endcase
            {rx_fifo_full, rx_fifo_empty} = k[1:0];
            @(negedge clk);
            `CHK(line_state_flags[3:2], k[1:0])
        end
        $display("test setup done");
        summarize();
    end
endmodule

// ### utic_ctrl.sv
// transmit holding port, interrupt enable/ident and fifo control of a channel
//
// Notes on behaviour
// [R1] a holding-port write appends the byte at the transmit queue tail
// [R2] a byte written while the transmit queue is full is dropped
// [R3] line state flags show transmit and receive queue full and empty
// [R4] enable bit 0 gates receive data ready; all enables reset to zero
// [R5] enable bit 1 gates the transmit holding empty interrupt
// [R6] enable bit 2 gates the receive line status interrupt
// [R7] enable bit 3 gates the modem status change interrupt
// [R8] enable bit 4 gates the software flow control interrupt
// [R9] bit 5 gates rts/dtr change, bit 6 cts/dsr change, bit 7 reserved
// [R10] ident bit 0 is zero while pending, one otherwise; resets to c1
// [R11] ident reports highest source: c6, c4, cc, c2, c0, d0 descending
// [R12] cts or rts change is lowest priority, reported as e0
// [R13] fifo setup bit 0 enables fifo mode; resets to zero
// [R14] writing one to setup bit 1 flushes receive queue, then self-clears
// [R15] writing one to setup bit 2 flushes transmit queue, then self-clears
// [R16] enhanced mode bits 5:4 pick transmit trigger 16, 32, 64, 112
// [R17] bits 7:6 pick receive trigger 1,4,8,14 or enhanced 15,31,63,111
// [R18] only enabled sources join priority selection and drive the request
// [R19] transmit-empty pending clears on ident read reporting it or on holding-port write
`timescale 1ns/1ns
module utic_ctrl (
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // transmit byte stream towards the serialiser
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output logic [7:0] tx_out_data,
    output logic [2:0] tx_level,
    // receive queue status and control
    input wire logic rx_fifo_empty,
    input wire logic rx_fifo_full,
    output logic rx_fifo_flush,
    // interrupt sources and enhanced mode, levels from the rest of the channel
    input wire logic src_rx_error,
    input wire logic src_rx_data,
    input wire logic src_rx_timeout,
    input wire logic src_modem,
    input wire logic src_xoff,
    input wire logic src_rts_dtr,
    input wire logic src_cts_dsr,
    input wire logic enhanced_mode,
    // results
    output logic irq_req,
    output logic [7:0] irq_enable_bits,
    output logic [7:0] irq_ident_code,
    output logic fifo_mode,
    output logic [6:0] tx_trigger,
    output logic [6:0] rx_trigger,
    output logic [3:0] line_state_flags
);
    logic wr_hold;
    logic wr_setup;
    logic rd_ident;
    logic tx_in_ready;
    logic tx_accept;
    logic tx_push;
    logic tx_pop;
    logic tx_flush;
    logic tx_empty;
    logic tx_full;
    logic txe_pend;
    logic txe_set;
    logic txe_clr;
    logic [1:0] tx_trig_sel;
    logic [1:0] rx_trig_sel;
    logic [6:0] src_vec;
    logic [6:0] active;
    logic [7:0] next_ident;

    assign wr_hold = reg_wr && (reg_addr == utic_pkg::OFS_TX_HOLDING);
    assign wr_setup = reg_wr && (reg_addr == utic_pkg::OFS_FIFO_SETUP);
    assign rd_ident = reg_rd && (reg_addr == utic_pkg::OFS_IRQ_IDENT);

    // transmit queue; outside fifo mode it holds a single byte
    assign tx_accept = tx_in_ready && (fifo_mode || tx_empty);
    assign tx_push = wr_hold && tx_accept; // [R1] [R2]
    assign tx_pop = tx_out_valid && tx_out_ready;
    assign tx_empty = (tx_level == utic_pkg::TX_CNT_ZERO);
    assign tx_full = !tx_accept;

    utic_fifo #(
        .WIDTH(utic_pkg::TX_WIDTH),
        .DEPTH(utic_pkg::TX_DEPTH),
        .CNT_W(utic_pkg::TX_CNT_W)
    ) u_tx_fifo (
        .clk(clk),
        .reset(reset),
        .clear(tx_flush),
        .in_valid(tx_push),
        .in_ready(tx_in_ready),
        .in_data(reg_wdata),
        .out_valid(tx_out_valid),
        .out_ready(tx_out_ready),
        .out_data(tx_out_data),
        .count(tx_level)
    );

    // queue state for the line status register
    always_comb begin
        line_state_flags = 4'h0;
        line_state_flags[utic_pkg::LS_TX_EMPTY] = tx_empty; // [R3]
        line_state_flags[utic_pkg::LS_TX_FULL] = tx_full; // [R3]
        line_state_flags[utic_pkg::LS_RX_EMPTY] = rx_fifo_empty; // [R3]
        line_state_flags[utic_pkg::LS_RX_FULL] = rx_fifo_full; // [R3]
    end

    // interrupt enables, bit 7 is stored but steers nothing
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_enable_bits <= utic_pkg::RST_IRQ_ENABLE; // [R4]
        end else if (reg_wr && (reg_addr == utic_pkg::OFS_IRQ_ENABLE)) begin
            irq_enable_bits <= reg_wdata;
        end
    end

    // fifo setup: mode and trigger selectors
    always_ff @(posedge clk) begin
        if (reset) begin
            fifo_mode <= 1'b0; // [R13]
            tx_trig_sel <= utic_pkg::RST_TRIG_SEL;
            rx_trig_sel <= utic_pkg::RST_TRIG_SEL;
        end else if (wr_setup) begin
            fifo_mode <= reg_wdata[utic_pkg::FS_FIFO_MODE]; // [R13]
            tx_trig_sel <= reg_wdata[utic_pkg::FS_TX_TRIG_LO +: 2]; // [R16]
            rx_trig_sel <= reg_wdata[utic_pkg::FS_RX_TRIG_LO +: 2]; // [R17]
        end
    end

    // flush bits stand one cycle, the queue empties on that edge
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_flush <= 1'b0;
            rx_fifo_flush <= 1'b0;
        end else begin
            tx_flush <= wr_setup && reg_wdata[utic_pkg::FS_TX_FLUSH]; // [R15]
            rx_fifo_flush <= wr_setup &&
                reg_wdata[utic_pkg::FS_RX_FLUSH]; // [R14]
        end
    end

    // trigger thresholds
    always_comb begin
        if (enhanced_mode) begin
            tx_trigger = utic_pkg::TX_TRIG_ENH[tx_trig_sel]; // [R16]
            rx_trigger = utic_pkg::RX_TRIG_ENH[rx_trig_sel]; // [R17]
        end else begin
            tx_trigger = utic_pkg::TX_TRIG_STD;
            rx_trigger = utic_pkg::RX_TRIG_STD[rx_trig_sel]; // [R17]
        end
    end

    // sticky transmit-empty event; a new event beats the clear
    assign txe_set = (tx_pop && !tx_push && (tx_level == utic_pkg::TX_CNT_ONE))
        || tx_flush;
    assign txe_clr = wr_hold ||
        (rd_ident && (irq_ident_code == utic_pkg::ID_TX_EMPTY)); // [R19]

    always_ff @(posedge clk) begin
        if (reset) begin
            txe_pend <= 1'b0;
        end else if (txe_set) begin
            txe_pend <= 1'b1;
        end else if (txe_clr) begin
            txe_pend <= 1'b0; // [R19]
        end
    end

    // source gating by the enable bits
    always_comb begin
        src_vec = 7'h00;
        src_vec[utic_pkg::IE_RX_DATA] = src_rx_data || src_rx_timeout;
        src_vec[utic_pkg::IE_TX_EMPTY] = txe_pend;
        src_vec[utic_pkg::IE_RX_ERROR] = src_rx_error;
        src_vec[utic_pkg::IE_MODEM] = src_modem;
        src_vec[utic_pkg::IE_XOFF] = src_xoff;
        src_vec[utic_pkg::IE_RTS_DTR] = src_rts_dtr;
        src_vec[utic_pkg::IE_CTS_DSR] = src_cts_dsr;
    end

    // [R4] [R5] [R6] [R7] [R8] [R9] [R18]
    assign active = src_vec & irq_enable_bits[utic_pkg::IE_NUM-1:0];
    assign irq_req = |active; // [R18]

    // priority encoder over enabled sources
    always_comb begin
        if (active[utic_pkg::IE_RX_ERROR]) begin
            next_ident = utic_pkg::ID_RX_ERROR; // [R11]
        end else if (active[utic_pkg::IE_RX_DATA] && src_rx_data) begin
            next_ident = utic_pkg::ID_RX_DATA; // [R11]
        end else if (active[utic_pkg::IE_RX_DATA]) begin
            next_ident = utic_pkg::ID_RX_TIMEOUT; // [R11]
        end else if (active[utic_pkg::IE_TX_EMPTY]) begin
            next_ident = utic_pkg::ID_TX_EMPTY; // [R11]
        end else if (active[utic_pkg::IE_MODEM]) begin
            next_ident = utic_pkg::ID_MODEM; // [R11]
        end else if (active[utic_pkg::IE_XOFF]) begin
            next_ident = utic_pkg::ID_XOFF; // [R11]
        end else if (active[utic_pkg::IE_RTS_DTR] ||
                     active[utic_pkg::IE_CTS_DSR]) begin
            next_ident = utic_pkg::ID_FLOW_CHG; // [R12]
        end else begin
            next_ident = utic_pkg::ID_NONE; // [R10]
        end
    end

    assign irq_ident_code = next_ident;

    // read data, one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= utic_pkg::RST_RDATA;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                if (reg_addr == utic_pkg::OFS_IRQ_ENABLE) begin
                    reg_rdata <= irq_enable_bits;
                end else if (reg_addr == utic_pkg::OFS_IRQ_IDENT) begin
                    reg_rdata <= irq_ident_code; // [R10]
                end else begin
                    reg_rdata <= utic_pkg::RST_RDATA;
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_full_drop: assert property ( // [R2]
        (wr_hold && tx_full && !tx_pop && !tx_flush) |=> $stable(tx_level))
        else $error("write to full transmit queue changed its level");

    a_push_count: assert property ( // [R1]
        (wr_hold && !tx_full && !tx_pop && !tx_flush)
        |=> (tx_level == $past(tx_level) + 3'h1))
        else $error("accepted byte did not raise the queue level");

    a_push_order: assert property ( // [R1]
        (wr_hold && tx_empty && !tx_pop && !tx_flush)
        |=> (tx_out_valid && tx_out_data == $past(reg_wdata)))
        else $error("byte written to empty queue is not at the head");

    a_line_flags: assert property ( // [R3]
        line_state_flags[utic_pkg::LS_TX_EMPTY] == (tx_level == 3'h0) &&
        line_state_flags[utic_pkg::LS_RX_FULL] == rx_fifo_full)
        else $error("line state flags disagree with queue state");

    a_ident_none: assert property ( // [R10]
        !irq_req |-> (irq_ident_code == 8'hc1))
        else $error("no pending source but ident is not c1");

    a_ident_bit0: assert property ( // [R10]
        irq_ident_code[0] == !irq_req)
        else $error("ident bit 0 does not track the request");

    a_ident_err: assert property ( // [R11]
        (src_rx_error && irq_enable_bits[2]) |-> (irq_ident_code == 8'hc6))
        else $error("receive error not reported at top priority");

    a_ident_txe: assert property ( // [R11]
        (txe_pend && irq_enable_bits[1] && !irq_enable_bits[0] &&
         !irq_enable_bits[2]) |-> (irq_ident_code == 8'hc2))
        else $error("transmit empty not reported as c2");

    a_lowest: assert property ( // [R12]
        (src_cts_dsr && irq_enable_bits[6] && active[5:0] == 6'h00)
        |-> (irq_ident_code == 8'he0))
        else $error("cts change alone not reported as e0");

    a_gate_modem: assert property ( // [R7]
        (!irq_enable_bits[3] && irq_enable_bits[2:0] == 3'h0 &&
         irq_enable_bits[6:4] == 3'h0) |-> !irq_req)
        else $error("request raised with every source disabled");

    a_gate_xoff: assert property ( // [R8]
        (src_xoff && irq_enable_bits[4] && active[3:0] == 4'h0)
        |-> (irq_ident_code == 8'hd0 && irq_req))
        else $error("enabled xoff source not reported");

    a_txe_clear: assert property ( // [R19]
        (rd_ident && irq_ident_code == 8'hc2 && !txe_set) |=> !txe_pend)
        else $error("ident read did not clear transmit empty");

    a_txe_wr: assert property ( // [R19]
        (wr_hold && !txe_set) |=> !txe_pend)
        else $error("holding write did not clear transmit empty");

    a_tx_flush: assert property ( // [R15]
        (wr_setup && reg_wdata[2]) |=> tx_flush ##1 (tx_level == 3'h0))
        else $error("transmit flush did not empty the queue");

    a_rx_flush: assert property ( // [R14]
        (wr_setup && reg_wdata[1]) |=> rx_fifo_flush
        ##1 (rx_fifo_flush == $past(wr_setup && reg_wdata[1])))
        else $error("receive flush did not pulse and self-clear");

    a_rx_trig: assert property ( // [R17]
        (!enhanced_mode && rx_trig_sel == 2'h3) |-> (rx_trigger == 7'h0e))
        else $error("standard receive trigger code 3 is not 14");

    a_tx_trig: assert property ( // [R16]
        (enhanced_mode && tx_trig_sel == 2'h3) |-> (tx_trigger == 7'h70))
        else $error("enhanced transmit trigger code 3 is not 112");

    a_mode_set: assert property ( // [R13]
        wr_setup |=> (fifo_mode == $past(reg_wdata[0])))
        else $error("fifo mode bit not taken from the write");

    a_ier_reset: assert property ( // [R4]
        $fell(reset) |-> (irq_enable_bits == 8'h00))
        else $error("interrupt enables not zero after reset");

    a_gate_rxdata: assert property ( // [R4]
        !irq_enable_bits[0] |->
        (irq_ident_code != 8'hc4 && irq_ident_code != 8'hcc))
        else $error("disabled receive data source was reported");

    a_gate_txe: assert property ( // [R5]
        !irq_enable_bits[1] |-> (irq_ident_code != 8'hc2))
        else $error("disabled transmit empty source was reported");

    a_gate_rxerr: assert property ( // [R6]
        !irq_enable_bits[2] |-> (irq_ident_code != 8'hc6))
        else $error("disabled receive error source was reported");

    a_gate_flow: assert property ( // [R9]
        (irq_enable_bits[6:5] == 2'h0) |-> (irq_ident_code != 8'he0))
        else $error("disabled flow change sources were reported");

    c_queue_full: cover property (wr_hold && tx_full);
    c_ident_txe: cover property (rd_ident && irq_ident_code == 8'hc2);
    c_flush: cover property (tx_flush && tx_level != 3'h0);
    c_flow_low: cover property (irq_ident_code == 8'he0);
    c_rx_flush: cover property (rx_fifo_flush);
endmodule

// ### utic_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module utic_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int CNT_W = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CNT_W-1:0] count
);
    // depth must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (count != FULL_CNT);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            if (push && !pop) begin
                count <= count + CNT_W'(1);
            end else if (pop && !push) begin
                count <= count - CNT_W'(1);
            end
        end
    end
endmodule

// ### utic_pkg.sv
// constants for the transmit port, interrupt and fifo control block
package utic_pkg;
    // register offsets
    localparam logic [7:0] OFS_TX_HOLDING = 8'h00;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h01;
    localparam logic [7:0] OFS_IRQ_IDENT = 8'h02;
    localparam logic [7:0] OFS_FIFO_SETUP = 8'h02;

    // reset values
    localparam logic [7:0] RST_TX_HOLDING = 8'h00;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_IRQ_IDENT = 8'hc1;
    localparam logic [1:0] RST_TRIG_SEL = 2'h0;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // irq_enable_bits field positions
    localparam int IE_RX_DATA = 0;
    localparam int IE_TX_EMPTY = 1;
    localparam int IE_RX_ERROR = 2;
    localparam int IE_MODEM = 3;
    localparam int IE_XOFF = 4;
    localparam int IE_RTS_DTR = 5;
    localparam int IE_CTS_DSR = 6;
    localparam int IE_NUM = 7;

    // irq_ident_code values
    localparam logic [7:0] ID_RX_ERROR = 8'hc6;
    localparam logic [7:0] ID_RX_DATA = 8'hc4;
    localparam logic [7:0] ID_RX_TIMEOUT = 8'hcc;
    localparam logic [7:0] ID_TX_EMPTY = 8'hc2;
    localparam logic [7:0] ID_MODEM = 8'hc0;
    localparam logic [7:0] ID_XOFF = 8'hd0;
    localparam logic [7:0] ID_FLOW_CHG = 8'he0;
    localparam logic [7:0] ID_NONE = 8'hc1;

    // fifo_setup_bits field positions
    localparam int FS_FIFO_MODE = 0;
    localparam int FS_RX_FLUSH = 1;
    localparam int FS_TX_FLUSH = 2;
    localparam int FS_TX_TRIG_LO = 4;
    localparam int FS_RX_TRIG_LO = 6;

    // trigger thresholds, indexed by the two-bit selector except the fixed standard transmit one
    localparam logic [6:0] TX_TRIG_ENH [4] = '{7'h10, 7'h20, 7'h40, 7'h70};
    localparam logic [6:0] RX_TRIG_STD [4] = '{7'h01, 7'h04, 7'h08, 7'h0e};
    localparam logic [6:0] RX_TRIG_ENH [4] = '{7'h0f, 7'h1f, 7'h3f, 7'h6f};
    localparam logic [6:0] TX_TRIG_STD = 7'h00;

    // line_state_flags positions
    localparam int LS_TX_EMPTY = 0;
    localparam int LS_TX_FULL = 1;
    localparam int LS_RX_EMPTY = 2;
    localparam int LS_RX_FULL = 3;

    // transmit queue shape
    localparam int TX_WIDTH = 8;
    localparam int TX_DEPTH = 4;
    localparam int TX_CNT_W = 3;
    localparam logic [TX_CNT_W-1:0] TX_CNT_ONE = 3'h1;
    localparam logic [TX_CNT_W-1:0] TX_CNT_ZERO = 3'h0;
endpackage

// ### utic_sink.sv
// model of the serialiser that takes bytes from the transmit stream
`timescale 1ns/1ns
module utic_sink (
    input wire logic clk,
    input wire logic reset,
    input wire logic hold,
    input wire logic valid,
    output logic ready,
    input wire logic [7:0] data,
    output logic taken,
    output logic [7:0] taken_data
);
    // ready moves only after the falling edge, stalls while hold
    always_ff @(negedge clk) begin
        ready <= !reset && !hold;
    end
    // one pulse per byte, in arrival order
    always_ff @(posedge clk) begin
        taken <= valid && ready && !reset;
        if (valid && ready) begin
            taken_data <= data;
        end
    end
endmodule
